// ### src/eeprom_guard_pkg.sv
// shared constants and carrier types of the protect and pause block
package eeprom_guard_pkg;
   // array geometry: 512 bytes, 32-byte pages
   localparam int ADDR_W = 9;
   localparam logic [8:0] PAGE_MASK = 9'h1e0;
   // lowest protected address for each protect-size code
   localparam logic [8:0] BASE_QUARTER = 9'h180;
   localparam logic [8:0] BASE_HALF = 9'h100;
   localparam logic [8:0] BASE_WHOLE = 9'h000;
   localparam logic [1:0] PROT_NONE = 2'h0;
   localparam logic [1:0] PROT_QUARTER = 2'h1;
   localparam logic [1:0] PROT_HALF = 2'h2;
   localparam logic [1:0] PROT_WHOLE = 2'h3;
   // value the protect cells take at a cold start
   localparam logic [1:0] PROTECT_COLD = 2'h0;
   // status byte bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_WEL = 1;
   localparam int ST_PROT_LO = 2;
   localparam int ST_PROT_HI = 3;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [15:0] TIMER_STEP = 16'h0001;

   typedef enum logic [1:0] {W_IDLE, W_ARRAY, W_STATUS} wstate_t;

   // one-cycle command strobes from the opcode decoder
   typedef struct packed {
      logic writeEnableCmd;
      logic writeDisableCmd;
      logic statusWriteCmd;
      logic arrayWriteCmd;
      logic [1:0] newProtect;
      logic [8:0] addr;
   } cmd_t;

   // system-clock state
   typedef struct packed {
      wstate_t st;
      logic busy;
      logic write_enable_latch;
      logic [15:0] timer;
      logic [1:0] pendProtect;
      logic accepted;
      logic refused;
      logic pausedFlag;
      logic pausedSeen;
      logic csPrev;
      logic abortPulse;
   } ctrl_t;

   // link state clocked on the rising serial clock
   typedef struct packed {
      logic [2:0] bitCount;
      logic [7:0] rxByte;
   } link_rise_t;

   // link state clocked on the falling serial clock
   typedef struct packed {
      logic paused;
      logic sdo;
      logic sdoEn;
   } link_fall_t;
endpackage

// ### src/protect_store.sv
// non-volatile protect-size cells with a registered read port
`timescale 1ns/1ns
`default_nettype none
module protect_store
   import eeprom_guard_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic coldStart, // first power application only
   input wire logic writeEn, // commit pulse
   input wire logic [1:0] writeData, // new protect size
   output logic [1:0] readData // registered cell contents
);
   logic [1:0] cells;

   // cells ignore the ordinary reset so the value survives it
   always_ff @(posedge clk)
   begin
      if (coldStart)
      begin
         cells <= PROTECT_COLD;
         readData <= PROTECT_COLD;
      end
      else
      begin
         if (writeEn)
            cells <= writeData;
         readData <= cells;
      end
   end
endmodule
`default_nettype wire

// ### src/serial_eeprom_protect_and_pause.sv
// write protection and bus-pause logic of a serial eeprom
// Summary of operation
// [RQ1] protect-size 00 none, 01 from 180h, 10 from 100h, 11 everything
// [RQ2] write-protect pin low refuses array and status writes
// [RQ3] write-protect pin low clears the write enable latch
// [RQ4] pause freezes the bit count so the transfer resumes in place
// [RQ5] while paused output floats, serial clock and data ignored; sdoEn drops only at the next falling serial clock edge
// [RQ6] host selects the device before pausing and keeps it selected
// [RQ7] deselect during pause resets link state and abandons transaction
// [RQ8] pause starts when pause input falls with serial clock low
// [RQ9] pause ends when pause input rises with serial clock low
// [RQ10] host keeps chip select high and steady during power ramps
// [RQ11] host waits a full write cycle before removing power
// [RQ12] protect size changes only by status write and is non-volatile
// [RQ13] array write to a page inside the protected region is ignored
// [RQ14] latch clear refuses array writes and status writes
// [RQ15] pause change with serial clock high waits for clock low
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_protect_and_pause
   import eeprom_guard_pkg::*;
#(
   parameter logic [15:0] WRITE_CYCLES = 16'h0064
) (
   input wire logic clk, // system clock, 20 MHz
   input wire logic reset, // synchronous, active high
   input wire logic powerOn, // cold start of the protect cells
   input wire logic sck, // serial clock from the host
   input wire logic csN, // chip select, active low
   input wire logic sdi, // serial data in
   input wire logic pauseN, // pause request, active low
   input wire logic writeProtectN, // write-protect pin, active low
   input wire cmd_t cmd, // decoded command strobes
   output logic sdo, // serial data out
   output logic sdoEn, // drive enable of sdo
   output logic [2:0] bitCount, // link bit position
   output logic [7:0] rxByte, // link shift register
   output logic paused, // pause state seen on clk
   output logic abortPulse, // deselect during pause
   output logic accepted, // command taken
   output logic refused, // command refused
   output logic writeEnableLatch, // latch state
   output logic [1:0] protectSize, // protect_size_hi/lo
   output logic writeBusy // self-timed cycle running
);
   // system-clock state and its next value
   ctrl_t ctrl_reg;
   ctrl_t ctrl_next;
   // link state, one copy for each serial clock edge
   link_rise_t rise_reg;
   link_rise_t rise_next;
   link_fall_t fall_reg;
   link_fall_t fall_next;
   // levels after crossing into the system clock
   logic wpSync;
   logic csSync;
   logic pausedSync;
   // protect cells, status image and its copy on the link side
   logic storeWrite;
   logic [1:0] protectNow;
   logic [7:0] statusByte;
   logic [7:0] statusLink;
   logic sckN;

   // lowest protected address of a protect-size code; code 00 is masked
   // off by the caller, so its base is never used
   function automatic logic [8:0] regionBase(input logic [1:0] size);
      unique case (size)
         PROT_QUARTER: regionBase = BASE_QUARTER;
         PROT_HALF: regionBase = BASE_HALF;
         PROT_NONE, PROT_WHOLE: regionBase = BASE_WHOLE;
      endcase
   endfunction

   // page lies inside the protected region when its base is at or above
   // the region base; the region bases are page aligned
   function automatic logic pageProtected(input logic [1:0] size,
                                          input logic [8:0] addr);
      logic [8:0] page;
      page = addr & PAGE_MASK;
      if (size == PROT_NONE)
         pageProtected = 1'b0;
      else
         pageProtected = (page >= regionBase(size)); // RQ1 RQ13
   endfunction

   // writes need the latch set and the protect pin released; a low pin
   // wins over a set latch even before the latch itself is cleared
   function automatic logic writeGate(input logic latch,
                                      input logic pinHigh);
      writeGate = latch && pinHigh; // RQ2 RQ14
   endfunction

   // any command strobe at all; a busy device refuses every one of them
   // so the host always learns that nothing was taken
   function automatic logic anyStrobe(input cmd_t c);
      anyStrobe = c.statusWriteCmd | c.arrayWriteCmd |
                  c.writeEnableCmd | c.writeDisableCmd;
   endfunction

   // status bit shown for a bit position, msb first
   function automatic logic [2:0] outBit(input logic [2:0] count);
      outBit = BIT_LAST - count;
   endfunction

   // pins and link state crossing into the system clock
   sync_2ff #(
      .WIDTH(3)
   ) pinSync (
      .clk(clk),
      .reset(reset),
      .d({writeProtectN, csN, fall_reg.paused}),
      .q({wpSync, csSync, pausedSync})
   );

   // protect size lives in cells that outlast reset
   protect_store protectCells (
      .clk(clk),
      .coldStart(powerOn),
      .writeEn(storeWrite),
      .writeData(ctrl_reg.pendProtect),
      .readData(protectNow)
   );

   // status image shifted out on the link
   always_comb
   begin
      statusByte = 8'h00;
      statusByte[ST_BUSY] = ctrl_reg.busy;
      statusByte[ST_WEL] = ctrl_reg.write_enable_latch;
      statusByte[ST_PROT_LO] = protectNow[0];
      statusByte[ST_PROT_HI] = protectNow[1];
   end

   // falling serial clock as a plain net for the status crossing
   assign sckN = ~sck;

   // status bits are slow levels; each is resynchronised on the falling
   // serial clock, so a change shows up two clock edges late
   sync_2ff #(
      .WIDTH(8)
   ) statusSync (
      .clk(sckN),
      .reset(1'b0),
      .d(statusByte),
      .q(statusLink)
   );

   // command handling on the system clock
   always_comb
   begin
      ctrl_next = ctrl_reg;
      ctrl_next.accepted = 1'b0;
      ctrl_next.refused = 1'b0;
      ctrl_next.abortPulse = 1'b0;
      storeWrite = 1'b0;
      unique case (ctrl_reg.st)
         W_IDLE:
         begin
            // status write has the highest priority of all strobes
            if (cmd.statusWriteCmd)
            begin
               if (writeGate(ctrl_reg.write_enable_latch, wpSync)) // RQ2 RQ14
               begin
                  ctrl_next.st = W_STATUS;
                  ctrl_next.busy = 1'b1;
                  ctrl_next.timer = '0;
                  ctrl_next.pendProtect = cmd.newProtect;
                  ctrl_next.accepted = 1'b1;
               end
               else
                  ctrl_next.refused = 1'b1;
            end
            else if (cmd.arrayWriteCmd)
            begin
               // array write also needs its page outside the region
               // RQ1 RQ13
               if (writeGate(ctrl_reg.write_enable_latch, wpSync) &&
                   !pageProtected(protectNow, cmd.addr)) // RQ2 RQ14
               begin
                  ctrl_next.st = W_ARRAY;
                  ctrl_next.busy = 1'b1;
                  ctrl_next.timer = '0;
                  ctrl_next.accepted = 1'b1;
               end
               else
                  ctrl_next.refused = 1'b1;
            end
            // latch set; a low protect pin undoes it below
            else if (cmd.writeEnableCmd)
            begin
               ctrl_next.write_enable_latch = 1'b1;
               ctrl_next.accepted = 1'b1;
            end
            // latch cleared on request
            else if (cmd.writeDisableCmd)
            begin
               ctrl_next.write_enable_latch = 1'b0;
               ctrl_next.accepted = 1'b1;
            end
         end
         W_ARRAY, W_STATUS:
         begin
            // nothing is taken while a self-timed cycle runs
            ctrl_next.refused = anyStrobe(cmd);
            // timer counts the self-timed cycle from zero
            ctrl_next.timer = ctrl_reg.timer + TIMER_STEP;
            if (ctrl_reg.timer == WRITE_CYCLES - TIMER_STEP)
            begin
               // old protect size holds until the cycle completes
               storeWrite = (ctrl_reg.st == W_STATUS); // RQ12
               ctrl_next.st = W_IDLE;
               ctrl_next.busy = 1'b0;
               ctrl_next.write_enable_latch = 1'b0;
            end
         end
      endcase
      // level-sensitive: a write enable cannot outlive a low pin
      if (!wpSync)
         ctrl_next.write_enable_latch = 1'b0; // RQ3

      // deselect seen while paused reports an abandoned transaction;
      // the link clears its own state, this only tells the system side
      ctrl_next.pausedFlag = pausedSync;
      ctrl_next.csPrev = csSync;
      if (!csSync)
         ctrl_next.pausedSeen = pausedSync;
      else
         ctrl_next.pausedSeen = 1'b0;
      if (csSync && !ctrl_reg.csPrev && ctrl_reg.pausedSeen)
         ctrl_next.abortPulse = 1'b1; // RQ7
   end

   // system-clock state register; reset leaves the protect cells alone,
   // only a cold start touches them
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctrl_reg <= '0;
         ctrl_reg.st <= W_IDLE;
         ctrl_reg.csPrev <= 1'b1;
      end
      else
         ctrl_reg <= ctrl_next;
   end

   // rising serial clock: shift in and count while not paused; the
   // pause level at this edge is the one left over from the low phase,
   // so the count freezes at the bit where the pause began
   always_comb
   begin
      rise_next = rise_reg;
      if (pauseN) // RQ5 RQ8 RQ9
      begin
         rise_next.bitCount = rise_reg.bitCount + 3'h1;
         rise_next.rxByte = {rise_reg.rxByte[6:0], sdi};
      end
   end

   // deselect clears the link at once; the clock may be stopped then
   always_ff @(posedge sck or posedge csN)
   begin
      if (csN)
         rise_reg <= '0; // RQ7
      else
         rise_reg <= rise_next; // RQ4
   end

   // falling serial clock: a pause change made while the clock was high
   // takes effect here, when the clock is low again
   always_comb
   begin
      fall_next = fall_reg;
      fall_next.paused = !pauseN; // RQ15
      fall_next.sdoEn = pauseN; // RQ5
      if (pauseN)
         fall_next.sdo = statusLink[outBit(rise_reg.bitCount)];
   end

   // output floats whenever the device is deselected; the clear is
   // asynchronous since the host may stop the clock while deselected
   always_ff @(negedge sck or posedge csN)
   begin
      if (csN)
         fall_reg <= '0; // RQ7
      else
         fall_reg <= fall_next; // RQ8 RQ9
   end

   // link outputs straight from the serial clock registers
   assign sdo = fall_reg.sdo;
   assign sdoEn = fall_reg.sdoEn;
   assign bitCount = rise_reg.bitCount;
   assign rxByte = rise_reg.rxByte;

   // command outputs straight from the system clock registers
   assign paused = ctrl_reg.pausedFlag;
   assign abortPulse = ctrl_reg.abortPulse;
   assign accepted = ctrl_reg.accepted;
   assign refused = ctrl_reg.refused;
   assign writeEnableLatch = ctrl_reg.write_enable_latch;
   assign protectSize = protectNow;
   assign writeBusy = ctrl_reg.busy;
endmodule
`default_nettype wire

// ### src/sync_2ff.sv
// two flip-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input wire logic clk, // destination clock
   input wire logic reset, // synchronous, active high
   input wire logic [WIDTH-1:0] d, // level from another domain
   output logic [WIDTH-1:0] q // synchronised level
);
   logic [WIDTH-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         meta <= '0;
         q <= '0;
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

// ### tb/eeprom_guard_monitor.sv
// port-level checks of the protect and pause block
`timescale 1ns/1ns
`default_nettype none
module eeprom_guard_monitor
   import eeprom_guard_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic reset, // sync reset
   input wire logic powerOn, // cell cold start
   input wire logic sck, // link clock
   input wire logic csN, // select
   input wire logic pauseN, // pause
   input wire logic writeProtectN, // protect pin
   input wire cmd_t cmd, // strobes
   input wire logic sdoEn, // out enable
   input wire logic [2:0] bitCount, // bit position
   input wire logic paused, // pause seen
   input wire logic abortPulse, // abort
   input wire logic refused, // refused
   input wire logic writeEnableLatch, // latch
   input wire logic [1:0] protectSize, // cells
   input wire logic writeBusy // busy
);
   // any write strobe, and whether its page is guarded
   wire logic wr = cmd.statusWriteCmd | cmd.arrayWriteCmd;
   wire logic inProt = protectSize == PROT_WHOLE
      || (protectSize == PROT_HALF && cmd.addr >= BASE_HALF)
      || (protectSize == PROT_QUARTER && cmd.addr >= BASE_QUARTER);

   wp_clears_latch_a: assert property (@(posedge clk) disable iff (reset)
      !writeProtectN [*5] |-> !writeEnableLatch)
      else $error("latch set under write protect");
   wp_refuses_a: assert property (@(posedge clk) disable iff (reset)
      !writeProtectN [*4] ##0 wr |=> refused)
      else $error("write taken under write protect");
   prot_region_a: assert property (@(posedge clk) disable iff (reset)
      cmd.arrayWriteCmd && !cmd.statusWriteCmd && inProt |=> refused)
      else $error("write to guarded page taken");
   latch_gate_a: assert property (@(posedge clk) disable iff (reset)
      wr && !writeEnableLatch |=> refused)
      else $error("write taken with latch clear");
   // cells move only on cold start or as a status write ends
   cells_hold_a: assert property (@(posedge clk) disable iff (reset)
      $changed(protectSize) |-> $past(powerOn) || $past(writeBusy, 2)
      || $past(writeBusy, 3) || $past(writeBusy, 4))
      else $error("protect cells changed unasked");
   out_float_a: assert property (@(negedge sck) disable iff (csN)
      !pauseN |=> !sdoEn)
      else $error("output driven while paused");
   count_freeze_a: assert property (@(posedge sck) disable iff (csN)
      !pauseN |=> $stable(bitCount))
      else $error("bit count moved while paused");
   count_advance_a: assert property (@(posedge sck) disable iff (csN)
      pauseN |=> bitCount == $past(bitCount) + 3'h1)
      else $error("bit count did not advance");
   deselect_abort_a: assert property (@(posedge clk) disable iff (reset)
      $rose(csN) && paused |-> ##[1:6] abortPulse)
      else $error("no abort on deselect in pause");
endmodule

bind serial_eeprom_protect_and_pause eeprom_guard_monitor u_mon (
   .clk(clk), .reset(reset), .powerOn(powerOn), .sck(sck), .csN(csN),
   .pauseN(pauseN), .writeProtectN(writeProtectN), .cmd(cmd),
   .sdoEn(sdoEn), .bitCount(bitCount), .paused(paused),
   .abortPulse(abortPulse), .refused(refused),
   .writeEnableLatch(writeEnableLatch), .protectSize(protectSize),
   .writeBusy(writeBusy)
);
`default_nettype wire

// ### tb/spi_host_model.sv
// host side of the serial link: clock, select, data, pause
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
   output var logic sck, // link clock, parked low
   output var logic csN, // select, active low
   output var logic sdi, // data to the device
   output var logic pauseN // pause, active low
);
   // idle and deselected from the start, no select glitches
   initial
   begin
      sck = 1'b0;
      csN = 1'b1;
      sdi = 1'b0;
      pauseN = 1'b1;
   end
   // released data shows the inverse, never a stale level
   task automatic select(input logic on);
      csN = !on;
      if (!on)
         sdi = !sdi;
      #9;
   endtask
   // msb first, 15 ns per bit, data steady over the rise
   task automatic send(input logic [7:0] v, input int n);
      for (int i = 7; i > 7 - n; i--)
      begin
         sdi = v[i];
         #8 sck = 1'b1;
         #7 sck = 1'b0;
      end
   endtask
   // pause change, selected or not; hi changes it with sck high
   task automatic pause(input logic on, input logic hi);
      if (hi)
         #8 sck = 1'b1;
      #3 pauseN = !on;
      if (hi)
         #4 sck = 1'b0;
      #5;
   endtask
endmodule
`default_nettype wire

// ### tb/test_serial_eeprom_protect_and_pause.sv
// self-checking bench for the protect and pause block
`timescale 1ns/1ns
`default_nettype none
module test_serial_eeprom_protect_and_pause
   import eeprom_guard_pkg::*;
;
   localparam logic [3:0] WEN = 4'h8;
   localparam logic [3:0] SWR = 4'h2;
   localparam logic [3:0] AWR = 4'h1;
   logic clk = 1'b0, reset = 1'b1, powerOn = 1'b1, writeProtectN = 1'b1;
   cmd_t cmd = '0;
   logic sck, csN, sdi, pauseN, sdo, sdoEn, paused, abortPulse;
   logic accepted, refused, writeEnableLatch, writeBusy;
   logic [2:0] bitCount;
   logic [7:0] rxByte;
   logic [1:0] protectSize;
   int mismatches = 0, total_checks = 0, n;
   logic [8:0] addrs [5] = '{9'h17f, 9'h180, 9'h0ff, 9'h100, 9'h000};

   // short self-timed cycle keeps the run brief
   serial_eeprom_protect_and_pause #(.WRITE_CYCLES(16'h0004)) u_dut (
      .clk(clk), .reset(reset), .powerOn(powerOn), .sck(sck), .csN(csN),
      .sdi(sdi), .pauseN(pauseN), .writeProtectN(writeProtectN),
      .cmd(cmd), .sdo(sdo), .sdoEn(sdoEn), .bitCount(bitCount),
      .rxByte(rxByte), .paused(paused), .abortPulse(abortPulse),
      .accepted(accepted), .refused(refused),
      .writeEnableLatch(writeEnableLatch), .protectSize(protectSize),
      .writeBusy(writeBusy));
   spi_host_model u_host (.sck(sck), .csN(csN), .sdi(sdi), .pauseN(pauseN));

   // 20 mhz system clock
   initial
   begin
      forever
         #25 clk = !clk;
   end

   task automatic check(input string what, input logic [8:0] exp,
      input logic [8:0] got);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // inputs move 2 ns after the edge, outputs read there too
   task automatic cycles(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   // one strobe for one cycle, answer one cycle later
   task automatic issue(input logic [3:0] s, input logic [1:0] p,
      input logic [8:0] a, input logic ok);
      cycles(1);
      cmd = {s, p, a};
      cycles(1);
      cmd = '0;
      check("answer", {ok, !ok}, {accepted, refused});
   endtask
   // bounded wait for the self-timed cycle to end
   task automatic waitIdle;
      n = 0;
      while (writeBusy !== 1'b0 && n < 100)
      begin
         cycles(1);
         n++;
      end
      if (n == 100)
      begin
         mismatches++;
         give_verdict();
      end
   endtask
   function automatic logic guarded(input logic [1:0] p,
      input logic [8:0] a);
      return p == PROT_WHOLE || (p == PROT_HALF && a >= BASE_HALF)
         || (p == PROT_QUARTER && a >= BASE_QUARTER);
   endfunction

   // main sequence
   initial
   begin
      cycles(8);
      reset = 1'b0;
      powerOn = 1'b0;
      cycles(3);
      check("protect", PROTECT_COLD, protectSize);
      issue(AWR, 2'h0, 9'h000, 1'b0);
      $display("done: reset");
      for (int p = 0; p < 4; p++)
      begin
         issue(WEN, 2'h0, 9'h000, 1'b1);
         issue(SWR, p[1:0], 9'h000, 1'b1);
         waitIdle();
         cycles(3);
         check("protect", p[1:0], protectSize);
         foreach (addrs[i])
         begin
            issue(WEN, 2'h0, 9'h000, 1'b1);
            issue(AWR, 2'h0, addrs[i], !guarded(p[1:0], addrs[i]));
            waitIdle();
         end
      end
      $display("done: protect sizes");
      issue(WEN, 2'h0, 9'h000, 1'b1);
      writeProtectN = 1'b0;
      cycles(5);
      check("latch", 1'b0, writeEnableLatch);
      issue(WEN, 2'h0, 9'h000, 1'b1);
      check("latch", 1'b0, writeEnableLatch);
      issue(SWR, 2'h0, 9'h000, 1'b0);
      writeProtectN = 1'b1;
      cycles(4);
      issue(WEN, 2'h0, 9'h000, 1'b1);
      issue(SWR, 2'h0, 9'h000, 1'b1);
      waitIdle();
      $display("done: write protect");
      u_host.select(1'b1);
      u_host.send(8'ha5, 3);
      check("enable", 1'b1, sdoEn);
      check("data out", 1'b0, sdo);
      u_host.pause(1'b1, 1'b0);
      u_host.send(8'h5a, 2);
      cycles(4);
      check("paused", 1'b1, paused);
      check("enable", 1'b0, sdoEn);
      check("count", 3'h3, bitCount);
      u_host.pause(1'b0, 1'b0);
      u_host.send(8'ha5 << 3, 5);
      check("byte", 8'ha5, rxByte);
      check("count", 3'h0, bitCount);
      cycles(4);
      u_host.select(1'b0);
      $display("done: pause");
      u_host.select(1'b1);
      u_host.pause(1'b1, 1'b1);
      u_host.send(8'hff, 4);
      cycles(4);
      check("count", 3'h1, bitCount);
      check("paused", 1'b1, paused);
      u_host.select(1'b0);
      n = 0;
      while (abortPulse !== 1'b1 && n < 10)
      begin
         cycles(1);
         n++;
      end
      check("abort", 1'b1, abortPulse);
      check("count", 3'h0, bitCount);
      u_host.pause(1'b0, 1'b0);
      $display("done: abort");
      give_verdict();
   end
endmodule
`default_nettype wire
